/* File: rtccal_top.sv */
/*
 Calendar counters of a real-time clock: weekday, day of month, month and
 two-digit year in BCD at addresses 0x03..0x06, with midnight carry.
 Assumes the serial interface presents decoded byte accesses (reg_addr,
 reg_wr, reg_rd) and that day_carry is a one-cycle pulse from the hours
 counter on its 23->00 rollover, aligned with the one-second tick.
*/
// Summary of operation
// - weekday at 0x03, bits 2..0, rest zero
// - date at 0x04, tens 5..4, units 3..0
// - date tens digit BCD 0 to 3
// - date units digit BCD 0 to 9
// - month at 0x05, tens bit 4, units 3..0
// - month tens 0 or 1, units 0..9
// - year at 0x06, tens 7..4, units 3..0
// - year digits each BCD 0 to 9
// - invalid values count on until rollover
// - calendar current within one second after switchover
`timescale 1ns/1ns
module rtccal_top (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            reg_hit,
	input  wire logic       day_carry,
	input  wire logic       main_supply_up,
	output logic            cal_valid
);
	import rtccal_pkg::*;

	// Register decode
	wire       sel_wday  = (reg_addr == ADDR_WEEKDAY);
	wire       sel_date  = (reg_addr == ADDR_DAY_MONTH);
	wire       sel_month = (reg_addr == ADDR_MONTH_NUM);
	wire       sel_year  = (reg_addr == ADDR_YEAR);
	wire       any_sel   = sel_wday | sel_date | sel_month | sel_year;
	wire [1:0] rd_idx    = sel_date ? IDX_DAY_MONTH : sel_month ? IDX_MONTH_NUM :
	                       sel_year ? IDX_YEAR : IDX_WEEKDAY;

	logic [31:0] all_data;
	wire  [7:0]  wday_q  = all_data[8*IDX_WEEKDAY   +: 8];
	wire  [7:0]  date_q  = all_data[8*IDX_DAY_MONTH +: 8];
	wire  [7:0]  month_q = all_data[8*IDX_MONTH_NUM +: 8];
	wire  [7:0]  year_q  = all_data[8*IDX_YEAR      +: 8];

	// BCD increment of one byte; an invalid units digit keeps counting in binary
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		logic [7:0] r;
		r = v;
		if (v[3:0] >= BCD_NINE) begin
			if (v[3:0] == BCD_NINE) begin
				r[3:0] = BCD_ZERO;
				r[7:4] = v[7:4] + BCD_TEN_STEP;
			end else begin
				r[3:0] = v[3:0] + BCD_TEN_STEP;
			end
		end else begin
			r[3:0] = v[3:0] + BCD_TEN_STEP;
		end
		return r;
	endfunction

	// Leap year: two-digit BCD year divisible by four
	wire       tens_odd  = year_q[4];
	wire [3:0] yu        = year_q[3:0];
	wire       leap      = tens_odd ? (yu == LEAP_ODD_A || yu == LEAP_ODD_B) :
	                       (yu == LEAP_EVEN_A || yu == LEAP_EVEN_B || yu == LEAP_EVEN_C);
	wire       short_mon = (month_q == MONTH_APR) || (month_q == MONTH_JUN) ||
	                       (month_q == MONTH_SEP) || (month_q == MONTH_NOV);
	wire [7:0] last_day  = (month_q == MONTH_FEB) ? (leap ? DAYS_29 : DAYS_28) :
	                       short_mon ? DAYS_30 : DAYS_31;

	// Equality to the limit rolls over; an invalid value past it keeps counting
	wire       date_roll  = (date_q == last_day);
	wire       month_roll = date_roll && (month_q == MONTH_DEC);
	wire       year_roll  = month_roll && (year_q == BCD_MAX_YEAR);
	wire [2:0] wday_next  = (wday_q[2:0] == WDAY_LAST) ? WDAY_FIRST :
	                        wday_q[2:0] + WDAY_FIRST;

	wire [7:0] date_next  = date_roll ? BCD_ONE : bcd_inc(date_q);
	wire [7:0] month_next = month_roll ? BCD_ONE : (date_roll ? bcd_inc(month_q) : month_q);
	wire [7:0] year_next  = year_roll ? RSVD_VALUE :
	                        (month_roll ? bcd_inc(year_q) : year_q);

	// Host write wins over a carry in the same cycle; the carry is then lost
	// because the host is setting a fresh time.
	wire        carry_go = day_carry && !reg_wr;
	wire [3:0]  wr_en    = {reg_wr & sel_year, reg_wr & sel_month, reg_wr & sel_date, reg_wr & sel_wday} |
	                       {4{carry_go}};
	wire [31:0] wr_data  = carry_go ?
	                       {year_next, month_next, date_next, RSVD_WDAY, wday_next} :
	                       {4{reg_wdata}};
	wire [31:0] wr_mask  = {MASK_YEAR, MASK_MONTH_NUM, MASK_DAY_MONTH, MASK_WEEKDAY};

	rtccal_regmem #(
		.DEPTH (NUM_REGS)
	) u_mem (
		.clk      (clk),
		.arst_n   (arst_n),
		.rd_idx   (rd_idx),
		.rd_data  (reg_rdata),
		.wr_en    (wr_en),
		.wr_data  (wr_data),
		.wr_mask  (wr_mask),
		.all_data (all_data)
	);

	// Read hit flags a mapped address one cycle later, aligned with reg_rdata
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			reg_hit <= 1'b0;
		else
			reg_hit <= reg_rd & any_sel;
	end

	// After switchover the fields are current by the next carry-aligned tick;
	// cal_valid drops while on backup and returns two cycles after the main
	// supply is back, well inside 1 s.
	rtccal_upd_t st_q, st_d;
	always_comb begin
		case (st_q)
			UPD_IDLE:  st_d = main_supply_up ? UPD_IDLE : UPD_SYNC;
			UPD_SYNC:  st_d = main_supply_up ? UPD_CARRY : UPD_SYNC;
			// A supply loss during the last step must not flag the calendar valid
			UPD_CARRY: st_d = main_supply_up ? UPD_IDLE : UPD_SYNC;
			default:   st_d = UPD_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			st_q <= UPD_SYNC;
		else
			st_q <= st_d;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			cal_valid <= 1'b0;
		else
			cal_valid <= (st_d == UPD_IDLE);
	end
endmodule // rtccal_top

/* File: rtccal_pkg.sv */
/*
 Package for the calendar register block: register addresses, field
 positions, day and month limits.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package rtccal_pkg;
	localparam logic [7:0] ADDR_WEEKDAY   = 8'h03;
	localparam logic [7:0] ADDR_DAY_MONTH = 8'h04;
	localparam logic [7:0] ADDR_MONTH_NUM = 8'h05;
	localparam logic [7:0] ADDR_YEAR      = 8'h06;
	localparam logic [1:0] IDX_WEEKDAY    = 2'h0;
	localparam logic [1:0] IDX_DAY_MONTH  = 2'h1;
	localparam logic [1:0] IDX_MONTH_NUM  = 2'h2;
	localparam logic [1:0] IDX_YEAR       = 2'h3;
	localparam logic [7:0] MASK_WEEKDAY   = 8'h07;
	localparam logic [7:0] MASK_DAY_MONTH = 8'h3f;
	localparam logic [7:0] MASK_MONTH_NUM = 8'h1f;
	localparam logic [7:0] MASK_YEAR      = 8'hff;
	localparam logic [2:0] WDAY_FIRST     = 3'h1;
	localparam logic [2:0] WDAY_LAST      = 3'h7;
	localparam logic [7:0] BCD_ONE        = 8'h01;
	localparam logic [7:0] BCD_MAX_YEAR   = 8'h99;
	localparam logic [7:0] MONTH_DEC      = 8'h12;
	localparam logic [7:0] MONTH_FEB      = 8'h02;
	localparam logic [7:0] MONTH_APR      = 8'h04;
	localparam logic [7:0] MONTH_JUN      = 8'h06;
	localparam logic [7:0] MONTH_SEP      = 8'h09;
	localparam logic [7:0] MONTH_NOV      = 8'h11;
	localparam logic [3:0] LEAP_ODD_A     = 4'h2;
	localparam logic [3:0] LEAP_ODD_B     = 4'h6;
	localparam logic [3:0] LEAP_EVEN_A    = 4'h0;
	localparam logic [3:0] LEAP_EVEN_B    = 4'h4;
	localparam logic [3:0] LEAP_EVEN_C    = 4'h8;
	localparam logic [4:0] RSVD_WDAY      = 5'h00;
	localparam logic [7:0] DAYS_28        = 8'h28;
	localparam logic [7:0] DAYS_29        = 8'h29;
	localparam logic [7:0] DAYS_30        = 8'h30;
	localparam logic [7:0] DAYS_31        = 8'h31;
	localparam logic [3:0] BCD_NINE       = 4'h9;
	localparam logic [3:0] BCD_ZERO       = 4'h0;
	localparam logic [3:0] BCD_TEN_STEP   = 4'h1;
	localparam logic [7:0] RSVD_VALUE     = 8'h00;
	localparam int         NUM_REGS       = 4;
	typedef enum logic [2:0] {
		UPD_IDLE  = 3'b001,
		UPD_CARRY = 3'b010,
		UPD_SYNC  = 3'b100
	} rtccal_upd_t;
endpackage

/* File: rtccal_regmem.sv */
/*
 Small register store for the four calendar bytes. Read data comes out of a
 register one clock after the address. Writes are masked per register.
 Assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
module rtccal_regmem #(
	parameter int DEPTH = 4
) (
	input  wire logic                     clk,
	input  wire logic                     arst_n,
	input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
	output logic      [7:0]               rd_data,
	input  wire logic [DEPTH-1:0]         wr_en,
	input  wire logic [DEPTH*8-1:0]       wr_data,
	input  wire logic [DEPTH*8-1:0]       wr_mask,
	output logic      [DEPTH*8-1:0]       all_data
);
	import rtccal_pkg::*;

	logic [7:0] store_q [DEPTH];

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_reg
			// Power-up contents are undefined; zero is one legal choice
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n)
					store_q[g] <= RSVD_VALUE;
				else if (wr_en[g])
					store_q[g] <= wr_data[g*8 +: 8] & wr_mask[g*8 +: 8];
			end
			assign all_data[g*8 +: 8] = store_q[g];
		end
	endgenerate

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			rd_data <= RSVD_VALUE;
		else
			rd_data <= store_q[rd_idx];
	end
endmodule // rtccal_regmem

/* File: rtccal_host.sv */
/*
 Host model: serial bus controller issuing single-byte register writes and reads.
 Assumes the byte strobes of rtccal_top, driven 1 ns after the rising edge.
*/
`timescale 1ns/1ns
module rtccal_host (
	input  wire logic       clk,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_hit
);
	initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
	// Data is passed as given, so a refusal case can set reserved bits
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(posedge clk) #1 reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
		@(posedge clk) #1 {reg_addr, reg_rd} = {a, 1'b1};
		@(posedge clk) #1 reg_rd = 1'b0;
		{d, h} = {reg_rdata, reg_hit};
	endtask
endmodule // rtccal_host

/* File: rtccal_checker.sv */
/*
 Checker for the calendar register block, bound to rtccal_top.
 Assumes one clock and the active-low asynchronous reset.
*/
`timescale 1ns/1ns
module rtccal_checker (
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_hit,
	input wire logic       day_carry,
	input wire logic       main_supply_up,
	input wire logic       cal_valid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	wire logic map_rd = reg_rd && reg_addr >= 8'h03 && reg_addr <= 8'h06;
	hit_on_read_a: assert property (map_rd |=> reg_hit)
		else $error("no hit after mapped read");
	no_stray_hit_a: assert property (!map_rd |=> !reg_hit)
		else $error("hit without mapped read");
	wday_rsvd_a: assert property (reg_addr == 8'h03 |=> reg_rdata[7:3] == 5'h00)
		else $error("weekday reserved bits set");
	date_rsvd_a: assert property (reg_addr == 8'h04 |=> reg_rdata[7:6] == 2'h0)
		else $error("date reserved bits set");
	month_rsvd_a: assert property (reg_addr == 8'h05 |=> reg_rdata[7:5] == 3'h0)
		else $error("month reserved bits set");
	year_back_a: assert property (reg_wr && reg_addr == 8'h06 ##1 reg_addr == 8'h06 && !reg_wr
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("year not read back");
	supply_valid_a: assert property ($rose(cal_valid) |-> main_supply_up)
		else $error("calendar valid without main supply");
	supply_drop_a: assert property (!main_supply_up |=> !cal_valid)
		else $error("calendar valid on backup supply");
	supply_back_a: assert property ($rose(main_supply_up) ##1 main_supply_up |-> ##1 cal_valid)
		else $error("calendar not valid after switchover");
	carry_wday_a: assert property (day_carry && !reg_wr && reg_addr == 8'h03 ##1 reg_addr == 8'h03 && !reg_wr
		|=> reg_rdata[2:0] == (($past(reg_rdata[2:0]) inside {3'h0, 3'h7}) ? 3'h1 : $past(reg_rdata[2:0]) + 3'h1))
		else $error("weekday did not advance");
endmodule // rtccal_checker
bind rtccal_top rtccal_checker u_chk (.clk, .arst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_hit,
	.day_carry, .main_supply_up, .cal_valid);

/* File: rtc_calendar_registers_tb.sv */
/*
 Testbench for the calendar register block: table of write/read rows, then reset, carry and invalid values.
 Assumes rtccal_top, the host model and the bound checker.
*/
`timescale 1ns/1ns
module rtc_calendar_registers_tb;
	logic       clk = 1'b0;
	logic       arst_n = 1'b0;
	logic       day_carry = 1'b0;
	logic       main_supply_up = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic       reg_wr, reg_rd, reg_hit, cal_valid, h;
	int         n_fail = 0;
	int         checks = 0;
	// Address, write data, expected read, expected hit
	logic [24:0] rows [7] = '{
		{8'h03, 8'hfd, 8'h05, 1'b1},
		{8'h04, 8'hff, 8'h3f, 1'b1},
		{8'h05, 8'hff, 8'h1f, 1'b1},
		{8'h06, 8'h99, 8'h99, 1'b1},
		{8'h07, 8'h55, 8'h05, 1'b0},
		{8'h04, 8'h31, 8'h31, 1'b1},
		{8'h05, 8'h12, 8'h12, 1'b1}};
	always #25 clk = ~clk;
	rtccal_top u_dut (.clk, .arst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_hit, .day_carry,
		.main_supply_up, .cal_valid);
	rtccal_host u_host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_hit);
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		u_host.rd(a, d, h);
		chk(d, e);
	endtask
	// Written year first so the address rests on the weekday for the carry check
	task automatic wr4(input logic [31:0] v);
		for (int i = 3; i >= 0; i--) u_host.wr(8'h03 + 8'(i), v[31-8*i -: 8]);
	endtask
	task automatic rd4(input logic [31:0] v);
		for (int i = 0; i < 4; i++) rdc(8'h03 + 8'(i), v[31-8*i -: 8]);
	endtask
	task automatic carry();
		@(posedge clk) #1 day_carry = 1'b1;
		@(posedge clk) #1 day_carry = 1'b0;
	endtask
	task automatic wrap_up();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Whole run is some 150 cycles; twenty times that is a hang
	initial begin
		#150000;
		n_fail++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge clk);
		#1 arst_n = 1'b1;
		rd4(32'h0);
		chk({7'h0, cal_valid}, 8'h01);
		foreach (rows[i]) begin
			u_host.wr(rows[i][24:17], rows[i][16:9]);
			u_host.rd(rows[i][24:17], d, h);
			chk(d, rows[i][8:1]);
			chk({7'h0, h}, {7'h0, rows[i][0]});
		end
		wr4(32'h07311299);
		carry();
		rd4(32'h01010100);
		wr4(32'h03280224);
		carry();
		rd4(32'h04290224);
		carry();
		rd4(32'h05010324);
		wr4(32'h00350106);
		carry();
		rd4(32'h01360106);
		// Host write in the carry cycle wins; the carry is dropped
		fork
			u_host.wr(8'h03, 8'h02);
			carry();
		join
		rd4(32'h02360106);
		@(posedge clk) #1 main_supply_up = 1'b0;
		repeat (3) @(posedge clk);
		#1 chk({7'h0, cal_valid}, 8'h00);
		main_supply_up = 1'b1;
		repeat (2) @(posedge clk);
		#1 chk({7'h0, cal_valid}, 8'h01);
		rd4(32'h02360106);
		@(posedge clk) #1 arst_n = 1'b0;
		@(posedge clk) #1 arst_n = 1'b1;
		chk({7'h0, cal_valid}, 8'h00);
		rd4(32'h0);
		chk({7'h0, cal_valid}, 8'h01);
		wrap_up();
	end
endmodule // rtc_calendar_registers_tb
